//--- inc/uisl_pkg.sv
// Package: register offsets, field positions, codes and timing for the interrupt/status block
package uisl_pkg;
    // ****************************************************************
    // Register map (byte addresses of the plain register port)
    // ****************************************************************
    localparam logic [3:0] UISL_OFF_LINE_STATE   = 4'h0;
    localparam logic [3:0] UISL_OFF_INT_MASK     = 4'h1;
    localparam logic [3:0] UISL_OFF_INT_SOURCE   = 4'h2;
    localparam logic [3:0] UISL_OFF_MODEM_STATUS = 4'h3;
    localparam logic [3:0] UISL_OFF_MODE         = 4'h4;
    localparam logic [3:0] UISL_OFF_TX_TRIGGER   = 4'h5;
    localparam logic [3:0] UISL_OFF_RX_TRIGGER   = 4'h6;
    localparam logic [3:0] UISL_OFF_CHAR_PERIOD  = 4'h7;

    // ****************************************************************
    // Mode register fields
    // ****************************************************************
    localparam int UISL_MODE_ENHANCED = 0;
    localparam int UISL_MODE_NINE_BIT = 1;
    localparam int UISL_MODE_ADDR_INT = 2;
    localparam int UISL_MODE_BYTE450  = 3;
    localparam int UISL_MODE_FIFO_EN  = 4;
    localparam int UISL_MODE_FLEX_TRG = 5;
    localparam int UISL_MODE_BIG_FIFO = 6;

    // ****************************************************************
    // Interrupt mask fields
    // ****************************************************************
    localparam int UISL_IE_RX_DATA  = 0;
    localparam int UISL_IE_TX_EMPTY = 1;
    localparam int UISL_IE_RX_STAT  = 2;
    localparam int UISL_IE_MODEM    = 3;
    localparam int UISL_IE_SLEEP    = 4;
    localparam int UISL_IE_SPECIAL  = 5;
    localparam int UISL_IE_RTS      = 6;
    localparam int UISL_IE_CTS      = 7;

    // ****************************************************************
    // Reset values
    // ****************************************************************
    localparam logic [7:0] UISL_RST_MASK     = 8'h00;
    localparam logic [7:0] UISL_RST_MODE     = 8'h00;
    localparam logic [7:0] UISL_RST_TX_TRG   = 8'h01;
    localparam logic [7:0] UISL_RST_RX_TRG   = 8'h01;
    localparam logic [15:0] UISL_RST_CHAR    = 16'h00c8;

    // ****************************************************************
    // Interrupt identification codes, bits [5:0]
    // ****************************************************************
    localparam logic [5:0] UISL_ID_NONE    = 6'h01;
    localparam logic [5:0] UISL_ID_RX_STAT = 6'h06;
    localparam logic [5:0] UISL_ID_RX_DATA = 6'h04;
    localparam logic [5:0] UISL_ID_TIMEOUT = 6'h0c;
    localparam logic [5:0] UISL_ID_TX_EMPT = 6'h02;
    localparam logic [5:0] UISL_ID_MODEM   = 6'h00;
    localparam logic [5:0] UISL_ID_SPECIAL = 6'h10;
    localparam logic [5:0] UISL_ID_FLOW    = 6'h20;

    // ****************************************************************
    // Timing
    // ****************************************************************
    localparam int UISL_TIMEOUT_CHARS = 4;
endpackage : uisl_pkg

//--- logic/uisl_core.sv
// Interrupt, line status and sleep-entry logic of a single UART channel
`timescale 1ns/1ps
module uisl_core
    import uisl_pkg::*;
#(
    parameter int LEVEL_W = 8
) (
    input  wire logic               ref_clk,
    input  wire logic               rst_n,
    input  wire logic               clk_en,
    input  wire logic [3:0]         reg_addr,
    input  wire logic [15:0]        reg_wdata,
    input  wire logic               reg_wr,
    input  wire logic               reg_rd,
    output logic      [15:0]        reg_rdata,
    input  wire logic [LEVEL_W-1:0] receive_fill_level,
    input  wire logic [LEVEL_W-1:0] transmit_fill_level,
    input  wire logic               rx_store,
    input  wire logic               rx_store_err,
    input  wire logic               rx_head_valid,
    input  wire logic               rx_pop,
    input  wire logic               rx_head_parity,
    input  wire logic               rx_head_framing,
    input  wire logic               rx_head_break,
    input  wire logic               rx_head_addr,
    input  wire logic               rx_overrun,
    input  wire logic               rx_stop_centre,
    input  wire logic               rx_idle,
    input  wire logic               tx_shift_empty,
    input  wire logic               tx_idle,
    input  wire logic               serial_input,
    input  wire logic               serial_output,
    input  wire logic [3:0]         modem_delta,
    input  wire logic               cts_pin,
    input  wire logic               rts_pin,
    input  wire logic               special_match,
    output logic                    channel_irq,
    output logic                    sleep_active
);
    // ****************************************************************
    // Pin synchronisers
    // ****************************************************************
    logic [2:0] pin_meta;
    logic [2:0] pin_sync;
    logic [1:0] flow_prev;
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            pin_meta <= 3'h7;
            pin_sync <= 3'h7;
        end else if (clk_en) begin
            pin_meta <= {serial_input, cts_pin, rts_pin};
            pin_sync <= pin_meta;
        end
    end
    wire sin_high = pin_sync[2];

    // ****************************************************************
    // Software registers
    // ****************************************************************
    logic [7:0]  int_mask;
    logic [7:0]  mode;
    logic [7:0]  tx_trigger;
    logic [7:0]  rx_trigger;
    logic [15:0] char_period;

    function automatic logic hit(input logic [3:0] a, input logic [3:0] off);
        hit = (a == off);
    endfunction : hit

    wire wr_mask  = reg_wr && hit(reg_addr, UISL_OFF_INT_MASK);
    wire wr_mode  = reg_wr && hit(reg_addr, UISL_OFF_MODE);
    wire wr_ttrg  = reg_wr && hit(reg_addr, UISL_OFF_TX_TRIGGER);
    wire wr_rtrg  = reg_wr && hit(reg_addr, UISL_OFF_RX_TRIGGER);
    wire wr_char  = reg_wr && hit(reg_addr, UISL_OFF_CHAR_PERIOD);
    wire rd_line  = reg_rd && hit(reg_addr, UISL_OFF_LINE_STATE);
    wire rd_src   = reg_rd && hit(reg_addr, UISL_OFF_INT_SOURCE);
    wire rd_modem = reg_rd && hit(reg_addr, UISL_OFF_MODEM_STATUS);

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            int_mask    <= UISL_RST_MASK;
            mode        <= UISL_RST_MODE;
            tx_trigger  <= UISL_RST_TX_TRG;
            rx_trigger  <= UISL_RST_RX_TRG;
            char_period <= UISL_RST_CHAR;
        end else if (clk_en) begin
            if (wr_mask) int_mask <= reg_wdata[7:0];
            if (wr_mode) mode <= reg_wdata[7:0];
            if (wr_ttrg) tx_trigger <= reg_wdata[7:0];
            if (wr_rtrg) rx_trigger <= reg_wdata[7:0];
            if (wr_char) char_period <= reg_wdata;
        end
    end

    wire enhanced = mode[UISL_MODE_ENHANCED];
    wire nine_bit = mode[UISL_MODE_NINE_BIT];
    wire byte450  = mode[UISL_MODE_BYTE450];
    wire fifo_on  = mode[UISL_MODE_FIFO_EN];

    // ****************************************************************
    // Line status flags
    // ****************************************************************
    logic overrun_flag;
    logic err_summary;
    // Ninth bit takes the parity slot in nine-bit framing
    wire  parity_bit  = rx_head_valid && (nine_bit ? rx_head_addr : rx_head_parity);
    wire  framing_bit = rx_head_valid && rx_head_framing;
    wire  break_bit   = rx_head_valid && rx_head_break;
    wire  tx_fifo_empty = (transmit_fill_level == '0);
    wire  tx_all_idle   = tx_fifo_empty && tx_shift_empty && tx_idle;
    // An errored entry cannot set the summary while the byte450 mode bit is set
    wire  err_entry = rx_store && rx_store_err && !byte450;

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            overrun_flag <= 1'b0;
            err_summary  <= 1'b0;
        end else if (clk_en) begin
            // Set wins over the clearing read
            overrun_flag <= rx_overrun || (overrun_flag && !rd_line);
            err_summary  <= err_entry || (err_summary && !rd_line);
        end
    end

    wire [7:0] line_state_flags = {err_summary && !byte450,
                                   tx_all_idle,
                                   tx_fifo_empty,
                                   break_bit, framing_bit, parity_bit,
                                   overrun_flag, rx_head_valid};

    // ****************************************************************
    // Interrupt sources
    // ****************************************************************
    wire rx_err_any = overrun_flag || framing_bit || break_bit;
    wire lvl1_norm  = (rx_err_any || parity_bit) && int_mask[UISL_IE_RX_STAT];
    wire lvl1_nine  = (rx_err_any && int_mask[UISL_IE_MODEM])
                   || (parity_bit && mode[UISL_MODE_ADDR_INT]
                       && int_mask[UISL_IE_RX_STAT]);
    wire src_l1  = nine_bit ? lvl1_nine : lvl1_norm;
    wire src_l2a = (receive_fill_level > rx_trigger[LEVEL_W-1:0])
                   && int_mask[UISL_IE_RX_DATA];

    // Receive timeout counter runs in character periods
    logic [15:0] tick_cnt;
    logic [2:0]  char_cnt;
    logic        timeout_flag;
    logic        timing;
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            tick_cnt     <= '0;
            char_cnt     <= '0;
            timeout_flag <= 1'b0;
            timing       <= 1'b0;
        end else if (clk_en) begin
            if (rx_pop || rx_stop_centre || !rx_head_valid || !fifo_on) begin
                tick_cnt     <= '0;
                char_cnt     <= '0;
                timing       <= rx_head_valid && fifo_on;
                timeout_flag <= 1'b0;
            end else if (timing && !timeout_flag) begin
                if (tick_cnt + 16'h0001 >= char_period) begin
                    tick_cnt <= '0;
                    char_cnt <= char_cnt + 3'h1;
                    if (char_cnt == 3'(UISL_TIMEOUT_CHARS - 1)) timeout_flag <= 1'b1;
                end else begin
                    tick_cnt <= tick_cnt + 16'h0001;
                end
            end
        end
    end
    wire src_l2b = timeout_flag && int_mask[UISL_IE_RX_DATA];

    // Transmit empty: edge of falling below trigger sets a sticky flag
    wire       flex_zero  = mode[UISL_MODE_FLEX_TRG] && (tx_trigger == 8'h00);
    wire [7:0] eff_trg    = enhanced ? tx_trigger : 8'h01;
    wire       tx_low     = flex_zero ? (tx_all_idle && serial_output)
                                      : (transmit_fill_level < LEVEL_W'(eff_trg));
    logic tx_low_q;
    logic tx_pend;
    logic mdm_pend;
    logic l5_pend;
    logic [1:0] l6_pend;
    logic [5:0] id_code;
    // One pending bit per pin so each has its own mask
    wire  [1:0] flow_rise = pin_sync[1:0] & ~flow_prev;
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            tx_low_q  <= 1'b1;
            tx_pend   <= 1'b0;
            mdm_pend  <= 1'b0;
            l5_pend   <= 1'b0;
            l6_pend   <= 2'h0;
            flow_prev <= 2'h3;
        end else if (clk_en) begin
            tx_low_q  <= tx_low;
            flow_prev <= pin_sync[1:0];
            tx_pend   <= (tx_low && !tx_low_q)
                      || (tx_pend && tx_low && !(rd_src && id_code == UISL_ID_TX_EMPT));
            mdm_pend  <= (|modem_delta) || (mdm_pend && !rd_modem);
            l5_pend   <= (enhanced && special_match)
                      || (l5_pend && !(rd_src && id_code == UISL_ID_SPECIAL));
            l6_pend   <= flow_rise
                      | (l6_pend & {2{!(rd_src && id_code == UISL_ID_FLOW)}});
        end
    end
    wire src_l3 = tx_pend && int_mask[UISL_IE_TX_EMPTY];
    wire src_l4 = mdm_pend && int_mask[UISL_IE_MODEM];
    wire src_l5 = l5_pend && enhanced && int_mask[UISL_IE_SPECIAL];
    wire src_l6 = enhanced
                  && |(l6_pend & {int_mask[UISL_IE_CTS], int_mask[UISL_IE_RTS]});

    // ****************************************************************
    // Priority encoding
    // ****************************************************************
    always_comb begin
        if (src_l1)       id_code = UISL_ID_RX_STAT;
        else if (src_l2a) id_code = UISL_ID_RX_DATA;
        else if (src_l2b) id_code = UISL_ID_TIMEOUT;
        else if (src_l3)  id_code = UISL_ID_TX_EMPT;
        else if (src_l4)  id_code = UISL_ID_MODEM;
        else if (src_l5)  id_code = UISL_ID_SPECIAL;
        else if (src_l6)  id_code = UISL_ID_FLOW;
        else              id_code = UISL_ID_NONE;
    end
    // In 750 mode bit 5 shows fifo size instead of level six
    wire bit5 = enhanced ? id_code[5] : (mode[UISL_MODE_BIG_FIFO] && fifo_on);
    wire [7:0] interrupt_source_code = {2'b00, bit5, id_code[4:0]};
    wire       any_pending = !id_code[0];

    // ****************************************************************
    // Sleep
    // ****************************************************************
    wire sleep_req = enhanced ? int_mask[UISL_IE_SLEEP]
                              : (int_mask[UISL_IE_SLEEP] || int_mask[UISL_IE_SPECIAL]);
    // Recomputed every cycle so a failing condition wakes at once
    wire sleep_ok  = sleep_req && tx_all_idle && sin_high && rx_idle
                     && !rx_head_valid && !any_pending;
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            sleep_active <= 1'b0;
            channel_irq  <= 1'b0;
        end else if (clk_en) begin
            sleep_active <= sleep_ok;
            channel_irq  <= any_pending;
        end
    end

    // ****************************************************************
    // Read port
    // ****************************************************************
    wire [7:0] mask_view = {int_mask[7:6],
                            int_mask[5] && (enhanced || sleep_active || !int_mask[5]),
                            int_mask[4] && (enhanced ? 1'b1 : sleep_active) ,
                            int_mask[3:0]};
    // Non-enhanced sleep request bits read back as achieved state
    wire [7:0] mask_rd = enhanced ? {int_mask[7:5], int_mask[4] && sleep_active, int_mask[3:0]}
                                  : mask_view;
    logic [15:0] next_rdata;
    always_comb begin
        next_rdata = 16'h0000;
        unique case (reg_addr)
            UISL_OFF_LINE_STATE:   next_rdata = {8'h00, line_state_flags};
            UISL_OFF_INT_MASK:     next_rdata = {8'h00, mask_rd};
            UISL_OFF_INT_SOURCE:   next_rdata = {8'h00, interrupt_source_code};
            UISL_OFF_MODEM_STATUS: next_rdata = {12'h000, modem_delta};
            UISL_OFF_MODE:         next_rdata = {8'h00, mode};
            UISL_OFF_TX_TRIGGER:   next_rdata = {8'h00, tx_trigger};
            UISL_OFF_RX_TRIGGER:   next_rdata = {8'h00, rx_trigger};
            UISL_OFF_CHAR_PERIOD:  next_rdata = char_period;
            default:               next_rdata = 16'h0000;
        endcase
    end
    always_ff @(posedge ref_clk) begin
        if (!rst_n) reg_rdata <= 16'h0000;
        else if (clk_en) reg_rdata <= reg_rd ? next_rdata : 16'h0000;
    end
endmodule : uisl_core

//--- verif/uisl_core_sva.sv
// Checker: port-level properties of the interrupt/status block
`timescale 1ns/1ps
module uisl_core_sva
    import uisl_pkg::*;
#(
    parameter int LEVEL_W = 8
) (
    input wire logic               ref_clk,
    input wire logic               rst_n,
    input wire logic [3:0]         reg_addr,
    input wire logic [15:0]        reg_wdata,
    input wire logic               reg_wr,
    input wire logic               reg_rd,
    input wire logic [15:0]        reg_rdata,
    input wire logic [LEVEL_W-1:0] transmit_fill_level,
    input wire logic               rx_idle,
    input wire logic               tx_shift_empty,
    input wire logic               tx_idle,
    input wire logic               channel_irq,
    input wire logic               sleep_active
);
    // ****************************************************************
    // Mask copy rebuilt from bus writes, so gating can be judged
    // ****************************************************************
    logic [7:0] mask_copy;
    wire        rd_src = reg_rd && reg_addr == UISL_OFF_INT_SOURCE;
    wire        rd_lsf = reg_rd && reg_addr == UISL_OFF_LINE_STATE;
    wire        rd_msk = reg_rd && reg_addr == UISL_OFF_INT_MASK;
    wire        no_req = !mask_copy[UISL_IE_SLEEP] && !mask_copy[UISL_IE_SPECIAL];
    wire        busy   = !rx_idle || !tx_shift_empty || transmit_fill_level != '0;

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            mask_copy <= 8'h00;
        end else if (reg_wr && reg_addr == UISL_OFF_INT_MASK) begin
            mask_copy <= reg_wdata[7:0];
        end
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    // ****************************************************************
    // Properties
    // ****************************************************************
    chk_code_legal: assert property (
        rd_src |=> reg_rdata[15:6] == 10'h000
            && reg_rdata[4:0] inside {5'h00, 5'h01, 5'h02, 5'h04, 5'h06, 5'h0c, 5'h10})
        else $error("source code read gave an undefined code");
    chk_txe_bit: assert property (
        rd_lsf |=> reg_rdata[5] == ($past(transmit_fill_level) == '0))
        else $error("tx empty bit disagrees with fill level");
    chk_idle_bit: assert property (
        rd_lsf |=> reg_rdata[6] == (reg_rdata[5] && $past(tx_shift_empty) && $past(tx_idle)))
        else $error("transmitter idle bit wrong");
    chk_mask_gates: assert property (
        (mask_copy == 8'h00) [*2] |-> !channel_irq)
        else $error("interrupt raised with all sources masked");
    chk_mask_rdback: assert property (
        rd_msk |=> (reg_rdata[7:0] & 8'hcf) == ($past(mask_copy) & 8'hcf))
        else $error("mask readback wrong");
    chk_sleep_req: assert property (
        no_req [*2] |-> !sleep_active)
        else $error("asleep without a request");
    chk_sleep_busy: assert property (
        busy [*2] |-> !sleep_active)
        else $error("asleep while channel busy");
    chk_sleep_rdback: assert property (
        rd_msk |=> !reg_rdata[UISL_IE_SLEEP] || $past(sleep_active))
        else $error("sleep bit read as one while awake");

    cov_flow: cover property (rd_src ##1 reg_rdata[5:0] == UISL_ID_FLOW);
    cov_sleep: cover property ($rose(sleep_active));
    cov_irq: cover property ($rose(channel_irq));
endmodule : uisl_core_sva

bind uisl_core uisl_core_sva #(.LEVEL_W(LEVEL_W)) u_sva (
    .ref_clk(ref_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .transmit_fill_level(transmit_fill_level), .rx_idle(rx_idle),
    .tx_shift_empty(tx_shift_empty), .tx_idle(tx_idle), .channel_irq(channel_irq),
    .sleep_active(sleep_active)
);

//--- verif/uisl_core_tb.sv
// Testbench: directed and random scenarios for the interrupt/status block
`timescale 1ns/1ps
module uisl_core_tb
    import uisl_pkg::*;
;
    localparam logic [3:0] SRC = UISL_OFF_INT_SOURCE;
    localparam logic [3:0] LSF = UISL_OFF_LINE_STATE;
    localparam logic [3:0] MSK = UISL_OFF_INT_MASK;
    logic        ref_clk, rst_n, clk_en, reg_wr, reg_rd;
    logic        rd_seen = 1'b0;
    logic [3:0]  reg_addr, modem_delta;
    logic [15:0] reg_wdata, reg_rdata;
    logic [7:0]  receive_fill_level, transmit_fill_level;
    logic        rx_store, rx_store_err, rx_head_valid, rx_pop, rx_head_parity, rx_head_framing;
    logic        rx_head_break, rx_head_addr, rx_overrun, rx_stop_centre, rx_idle, tx_shift_empty;
    logic        tx_idle, serial_input, serial_output, cts_pin, rts_pin, special_match;
    logic        channel_irq, sleep_active;
    logic [31:0] note;
    logic [31:0] exp_q[$];
    logic [2:0]  trg, fill;
    int          error_cnt, tests_run, seed;

    uisl_core #(.LEVEL_W(8)) DUT (
        .ref_clk(ref_clk), .rst_n(rst_n), .clk_en(clk_en), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .receive_fill_level(receive_fill_level), .transmit_fill_level(transmit_fill_level),
        .rx_store(rx_store), .rx_store_err(rx_store_err), .rx_head_valid(rx_head_valid),
        .rx_pop(rx_pop), .rx_head_parity(rx_head_parity), .rx_head_framing(rx_head_framing),
        .rx_head_break(rx_head_break), .rx_head_addr(rx_head_addr), .rx_overrun(rx_overrun),
        .rx_stop_centre(rx_stop_centre), .rx_idle(rx_idle), .tx_shift_empty(tx_shift_empty),
        .tx_idle(tx_idle), .serial_input(serial_input), .serial_output(serial_output),
        .modem_delta(modem_delta), .cts_pin(cts_pin), .rts_pin(rts_pin),
        .special_match(special_match), .channel_irq(channel_irq), .sleep_active(sleep_active)
    );

    // ****************************************************************
    // Bus tasks, result checker and verdict
    // ****************************************************************
    task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : cmp

    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge ref_clk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge ref_clk);
        reg_wr    <= 1'b0;
    endtask : wr

    // Expected value is noted with a mask of the bits this read judges
    task automatic rd(input logic [3:0] a, input logic [15:0] v, input logic [15:0] m);
        @(posedge ref_clk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        exp_q.push_back({m, v});
        @(posedge ref_clk);
        reg_rd   <= 1'b0;
    endtask : rd

    task automatic see(input logic [1:0] v);
        @(negedge ref_clk);
        cmp({14'h0, sleep_active, channel_irq}, {14'h0, v});
        @(posedge ref_clk);
    endtask : see

    task automatic idle(input int n);
        repeat (n) @(posedge ref_clk);
    endtask : idle

    task automatic end_of_test();
        if (error_cnt == 0 && tests_run > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : end_of_test

    // Read data stand only in the cycle after the strobe
    always @(posedge ref_clk) begin
        if (rd_seen) begin
            note = exp_q.pop_front();
            cmp(reg_rdata & note[31:16], note[15:0]);
        end
        rd_seen <= reg_rd;
    end

    initial begin
        ref_clk = 1'b0;
        forever #2.5 ref_clk = ~ref_clk;
    end

    initial begin
        repeat (20000) @(posedge ref_clk);
        error_cnt++;
        end_of_test();
    end

    initial begin
        {rst_n, reg_wr, reg_rd, reg_addr, reg_wdata, modem_delta} = '0;
        {receive_fill_level, transmit_fill_level, rx_store, rx_store_err, rx_head_valid} = '0;
        {rx_pop, rx_head_parity, rx_head_framing, rx_head_break, rx_head_addr} = '0;
        {rx_overrun, rx_stop_centre, cts_pin, rts_pin, special_match} = '0;
        {clk_en, rx_idle, tx_shift_empty, tx_idle, serial_input, serial_output} = '1;
        seed = 42156;
        repeat (20) @(posedge ref_clk);
        rst_n <= 1'b1;
        rd(MSK, 16'h0000, 16'hffff);
        rd(SRC, 16'h0001, 16'h003f);
        rd(4'hc, 16'h0000, 16'hffff);
        rd(LSF, 16'h0060, 16'h0060);
        tx_idle <= 1'b0;
        idle(2);
        rd(LSF, 16'h0020, 16'h0060);
        tx_idle             <= 1'b1;
        transmit_fill_level <= 8'h03;
        idle(2);
        rd(LSF, 16'h0000, 16'h0060);
        // Non-enhanced 128-deep mode shows bit 5 even with nothing pending
        wr(UISL_OFF_MODE, 16'h0050);
        rd(SRC, 16'h0021, 16'h003f);
        // Enhanced, FIFO on, flexible triggers
        wr(UISL_OFF_MODE, 16'h0031);
        rd(SRC, 16'h0001, 16'h003f);
        wr(MSK, 16'h0002);
        transmit_fill_level <= 8'h00;
        idle(2);
        see(2'b01);
        rd(SRC, 16'h0002, 16'h003f);
        rd(SRC, 16'h0001, 16'h003f);
        transmit_fill_level <= 8'h03;
        tx_shift_empty      <= 1'b0;
        wr(UISL_OFF_TX_TRIGGER, 16'h0000);
        transmit_fill_level <= 8'h00;
        idle(3);
        rd(SRC, 16'h0001, 16'h003f);
        tx_shift_empty <= 1'b1;
        idle(3);
        rd(SRC, 16'h0002, 16'h003f);
        // Overrun outranks data available; line read clears both flags
        wr(MSK, 16'h0005);
        receive_fill_level <= 8'h02;
        rx_head_valid      <= 1'b1;
        idle(3);
        rd(SRC, 16'h0004, 16'h003f);
        {rx_overrun, rx_store, rx_store_err} <= 3'h7;
        @(posedge ref_clk);
        {rx_overrun, rx_store, rx_store_err} <= 3'h0;
        idle(2);
        rd(SRC, 16'h0006, 16'h003f);
        rd(LSF, 16'h0082, 16'h0082);
        rd(LSF, 16'h0000, 16'h0082);
        rd(SRC, 16'h0004, 16'h003f);
        wr(MSK, 16'h0004);
        idle(2);
        see(2'b00);
        {receive_fill_level, rx_head_valid} <= '0;
        wr(MSK, 16'h0008);
        modem_delta <= 4'h2;
        idle(3);
        rd(SRC, 16'h0000, 16'h003f);
        modem_delta <= 4'h0;
        rd(UISL_OFF_MODEM_STATUS, 16'h0000, 16'hffff);
        rd(SRC, 16'h0001, 16'h003f);
        wr(MSK, 16'h0020);
        special_match <= 1'b1;
        @(posedge ref_clk);
        special_match <= 1'b0;
        idle(2);
        rd(SRC, 16'h0010, 16'h003f);
        rd(SRC, 16'h0001, 16'h003f);
        wr(MSK, 16'h0080);
        cts_pin <= 1'b1;
        idle(4);
        rd(SRC, 16'h0020, 16'h003f);
        rd(SRC, 16'h0001, 16'h003f);
        wr(MSK, 16'h0040);
        rts_pin <= 1'b1;
        idle(4);
        rd(SRC, 16'h0020, 16'h003f);
        wr(MSK, 16'h0000);
        {cts_pin, rts_pin} <= 2'b00;
        wr(MSK, 16'h00c0);
        idle(4);
        rd(SRC, 16'h0001, 16'h003f);
        // Sleep entry, exit on a falling line, re-entry, manual wake
        wr(MSK, 16'h0010);
        idle(6);
        see(2'b10);
        rd(MSK, 16'h0010, 16'h00ff);
        serial_input <= 1'b0;
        idle(5);
        see(2'b00);
        rd(MSK, 16'h0000, 16'h0010);
        serial_input <= 1'b1;
        idle(6);
        see(2'b10);
        wr(MSK, 16'h0000);
        idle(3);
        see(2'b00);
        // A write while the clock enable is low must not land
        clk_en <= 1'b0;
        wr(UISL_OFF_RX_TRIGGER, 16'h00ff);
        clk_en <= 1'b1;
        rd(UISL_OFF_RX_TRIGGER, 16'h0001, 16'hffff);
        // Random fills and triggers with the receive side chattering
        wr(MSK, 16'h0001);
        for (int i = 0; i < 40; i++) begin
            trg = 3'($random(seed));
            fill = 3'($random(seed));
            wr(UISL_OFF_RX_TRIGGER, {13'h0, trg});
            receive_fill_level <= {5'h0, fill};
            {rx_store, rx_store_err, rx_pop, rx_overrun, rx_stop_centre, special_match,
             rx_head_parity, rx_head_framing, rx_head_break, rx_head_addr,
             rx_head_valid} <= 11'($random(seed));
            @(posedge ref_clk);
            {rx_store, rx_pop, rx_overrun, rx_stop_centre, special_match} <= 5'h00;
            idle(2);
            see({1'b0, fill > trg});
            rd(SRC, (fill > trg) ? 16'h0004 : 16'h0001, 16'h003f);
        end
        // Timeout after four short character periods; a pop clears it
        wr(UISL_OFF_CHAR_PERIOD, 16'h0004);
        receive_fill_level <= 8'h00;
        {rx_head_valid, rx_head_break, rx_stop_centre} <= 3'h7;
        @(posedge ref_clk);
        rx_stop_centre <= 1'b0;
        idle(12);
        rd(SRC, 16'h0001, 16'h003f);
        rd(LSF, 16'h0011, 16'h0011);
        idle(8);
        rd(SRC, 16'h000c, 16'h003f);
        rx_pop <= 1'b1;
        @(posedge ref_clk);
        rx_pop <= 1'b0;
        rd(SRC, 16'h0001, 16'h003f);
        idle(3);
        end_of_test();
    end
endmodule : uisl_core_tb
